// >>> verilog/pmic_ctrl_pkg.sv
// Constants for the power path and charger control register bank
package pmic_ctrl_pkg;
  // ----------------------------------------------------------------
  // Register indices, masks, reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PATH_IDX = 8'h30;
  localparam logic [7:0] WAKE_IDX = 8'h31;
  localparam logic [7:0] PWR_IDX = 8'h32;
  localparam logic [7:0] CHG1_IDX = 8'h33;
  localparam logic [7:0] CHG2_IDX = 8'h34;
  localparam logic [7:0] PATH_RST = 8'h01;
  localparam logic [7:0] WAKE_RST = 8'h03;
  localparam logic [7:0] PWR_RST = 8'h43;
  localparam logic [7:0] CHG1_RST = 8'hC5;
  localparam logic [7:0] CHG2_RST = 8'h45;
  // Bits restored by system reset
  localparam logic [7:0] PATH_SYS_MASK = 8'h84;
  localparam logic [7:0] WAKE_SYS_MASK = 8'h08;
  localparam logic [7:0] PWR_SYS_MASK = 8'h80;
  localparam logic [7:0] CHG1_SYS_MASK = 8'h80;
  localparam logic [7:0] PATH_WMASK = 8'hBF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] SEL_NONE = 3'h7;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PATH_SEL_BIT = 7;
  localparam int PATH_RSV_BIT = 6;
  localparam int HOLD_LSB = 3;
  localparam int DRIVE_BIT = 2;
  localparam int ILIM_LSB = 0;
  localparam int PG_LOW_BIT = 7;
  localparam int RESTART_BIT = 6;
  localparam int SOFTWAKE_BIT = 5;
  localparam int IRQ_NOWAKE_BIT = 4;
  localparam int WAKE_EN_BIT = 3;
  localparam int SHUTDOWN_VOLTAGE_LSB = 0;
  localparam int PWR_OFF_BIT = 7;
  localparam int BATDET_BIT = 6;
  localparam int LED_LSB = 4;
  localparam int LED_SRC_BIT = 3;
  localparam int REVERSE_BIT = 2;
  localparam int PG_DLY_LSB = 0;
  localparam int CHG_EN_BIT = 7;
  localparam int TARGET_LSB = 5;
  localparam int END_BIT = 4;
  localparam int ICHG_LSB = 0;
  localparam int PRE_LSB = 6;
  localparam int KEEP_ON_BIT = 5;
  localparam int LED_TYPE_BIT = 4;
  localparam int PASS_LIM_BIT = 3;
  localparam int TRACK_BIT = 2;
  localparam int FAST_LSB = 0;
  // ----------------------------------------------------------------
  // Encodings and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] ICHG_MAX_CODE = 4'hD;
  localparam logic [15:0] ICHG_STEP_MA = 16'h00C8;
  localparam logic [11:0] ILIM_MA_00 = 12'd900;
  localparam logic [11:0] ILIM_MA_01 = 12'd1500;
  localparam logic [11:0] ILIM_MA_10 = 12'd2000;
  localparam logic [11:0] ILIM_MA_11 = 12'd2500;
  localparam logic [3:0] END_MUL_10PCT = 4'hA;
  localparam logic [3:0] END_MUL_20PCT = 4'h5;
  localparam logic [1:0] LED_HIZ = 2'h0;
  localparam logic [1:0] LED_SLOW = 2'h1;
  localparam logic [1:0] LED_FAST = 2'h2;
  localparam logic [3:0] LED_SLOW_ON = 4'h4;
  localparam logic [1:0] LED_FAST_PH = 2'h0;
  localparam int CLK_HZ = 10_000_000;
  localparam int PASS_ON_US = 32;
  localparam int PASS_ON_CYC = PASS_ON_US * (CLK_HZ / 1_000_000);
  localparam int LED_TICK_MS = 125;
  localparam int LED_TICK_CYC = LED_TICK_MS * (CLK_HZ / 1000);
  localparam int PG_TICK_MS = 8;
  localparam int PG_TICK_CYC = PG_TICK_MS * (CLK_HZ / 1000);
  localparam int MINUTE_S = 60;
  localparam int MINUTE_CYC = MINUTE_S * CLK_HZ;
  localparam logic [9:0] PRE_BASE_MIN = 10'd40;
  localparam logic [9:0] PRE_STEP_MIN = 10'd10;
  localparam logic [9:0] FAST_BASE_MIN = 10'd360;
  localparam logic [9:0] FAST_STEP_MIN = 10'd120;
  typedef enum logic [2:0] {
    PG_LOW = 3'b001,
    PG_WAIT = 3'b010,
    PG_GOOD = 3'b100
  } pg_state_e;
endpackage : pmic_ctrl_pkg

// >>> verilog/power_path_charger_regs.sv
// Power path, wakeup, LED and charger control register bank
//
// Behaviour
// R1: Path register resets to 01H; bits 7 and 2 follow system reset, rest power-on.
// R2: Path select bit 7 at 0 picks the USB input path, 1 deselects it.
// R3: Hold-voltage field bits 5:3 spans 4.0V to 4.7V, resets to 000.
// R4: Bit 2 drives the supply-drive pin low at 0, high at 1.
// R5: Bits 1:0 pick the non-standard-port default current limit, 900 to 2500mA.
// R6: Wakeup register resets to 03H; bit 3 follows system reset, rest power-on.
// R7: Writing 1 to bit 6 restarts the rails and the bit self-clears.
// R8: Writing 1 to bit 5 wakes the rails and the bit self-clears.
// R9: Bit 3 enables wakeup from interrupt sources and self-clears once used.
// R10: With wake enable, bit 4 at 0 masks the pin and lets interrupts wake.
// R11: Bit 7 at 1 holds power-good low through the wakeup period; the code holds it only for wakeups while bit 3 is set.
// R12: Shutdown-voltage field bits 2:0 spans 2.6V to 3.3V, resets to 011.
// R13: Writing 1 to power-disable bit 7 turns off regulators, then self-clears.
// R14: LED field picks high impedance, 25% 0.5Hz, 25% 2Hz or low.
// R15: Bit 3 hands the LED pin to software field or charger logic.
// R16: Bit 2 picks simultaneous or reverse-order shutdown.
// R17: Bits 1:0 set power-good delay 8, 16, 32 or 64ms; reset 11.
// R18: Charger register 1 resets to C5H; bit 7 system reset, rest power-on.
// R19: Charge is complete below 10% of set current, or 20% if bit 4.
// R20: Charge current is 200mA per step, codes 1110-1111 reserved, reset 0101.
// R21: Precharge timer 40 to 70 minutes, fast-charge timer 6 to 12 hours.
// R22: With bit 3 set, the pass transistor is cut after 32us continuous on-time.
// R23: Reserved bits ignore writes and read as zero.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns
module power_path_charger_regs
  import pmic_ctrl_pkg::*;
#(
  parameter int LED_TICK_CYCLES = LED_TICK_CYC,
  parameter int PG_TICK_CYCLES = PG_TICK_CYC,
  parameter int MINUTE_CYCLES = MINUTE_CYC
) (
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sys_resetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Power path
  output logic usb_path_select,
  output logic [2:0] input_hold_voltage,
  output logic supply_drive_pin,
  output logic [11:0] default_ilim_ma,
  // Wakeup and power control
  input wire logic irq_request,
  input wire logic rails_good,
  output logic irq_pin_masked,
  output logic rail_restart,
  output logic rail_wakeup,
  output logic rails_disable,
  output logic power_down_reverse,
  output logic power_good_output,
  output logic [2:0] shutdown_voltage,
  output logic battery_detect_en,
  // Charge LED pin
  input wire logic charger_led_request,
  output logic charge_led_pin_out,
  output logic charge_led_pin_oe,
  output logic charger_led_type_b,
  // Charger
  input wire logic precharge_active,
  input wire logic fastcharge_active,
  input wire logic [11:0] charge_current_ma,
  input wire logic pass_on_request,
  output logic charger_enable,
  output logic [1:0] charger_target,
  output logic [3:0] charge_current_code,
  output logic charger_keep_on,
  output logic target_tracks_current,
  output logic charge_done,
  output logic charge_timeout,
  output logic pass_gate
);
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    if (addr == {PATH_IDX[5:0], 2'b00}) return 3'h0;
    if (addr == {WAKE_IDX[5:0], 2'b00}) return 3'h1;
    if (addr == {PWR_IDX[5:0], 2'b00}) return 3'h2;
    if (addr == {CHG1_IDX[5:0], 2'b00}) return 3'h3;
    if (addr == {CHG2_IDX[5:0], 2'b00}) return 3'h4;
    return SEL_NONE;
  endfunction : reg_sel

  logic [7:0] path_reg, wake_reg, pwr_reg, chg1_reg, chg2_reg;
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [7:0] rdata_reg;
  logic do_write;
  logic [2:0] wsel;
  logic [4:0] wr_hit;
  logic wake_fire;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready = !w_held_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = {24'h000000, rdata_reg};
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wsel = reg_sel(aw_addr_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else if (wvalid && wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= wdata[7:0];
      w_lane_reg <= wstrb[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 8'h00;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= (reg_sel(araddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (reg_sel(araddr))
        3'h0: rdata_reg <= path_reg;
        3'h1: rdata_reg <= wake_reg;
        3'h2: rdata_reg <= pwr_reg;
        3'h3: rdata_reg <= chg1_reg;
        3'h4: rdata_reg <= chg2_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // One write strobe per register
  generate
    for (genvar i = 0; i < 5; i++) begin : g_hit
      assign wr_hit[i] = do_write && w_lane_reg && (wsel == 3'(i));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      path_reg <= PATH_RST; // R1
    end else if (!sys_resetn) begin
      path_reg <= (path_reg & ~PATH_SYS_MASK) | (PATH_RST & PATH_SYS_MASK); // R1
    end else if (wr_hit[0]) begin
      path_reg <= w_data_reg & PATH_WMASK; // R23
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_reg <= WAKE_RST; // R6
    end else if (!sys_resetn) begin
      wake_reg <= (wake_reg & ~WAKE_SYS_MASK) | (WAKE_RST & WAKE_SYS_MASK); // R6
    end else if (wr_hit[1]) begin
      wake_reg <= w_data_reg;
    end else begin
      wake_reg[RESTART_BIT] <= 1'b0; // R7
      wake_reg[SOFTWAKE_BIT] <= 1'b0; // R8
      if (wake_fire) begin
        wake_reg[WAKE_EN_BIT] <= 1'b0; // R9
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_reg <= PWR_RST;
    end else if (!sys_resetn) begin
      pwr_reg <= (pwr_reg & ~PWR_SYS_MASK) | (PWR_RST & PWR_SYS_MASK);
    end else if (wr_hit[2]) begin
      pwr_reg <= w_data_reg;
    end else begin
      pwr_reg[PWR_OFF_BIT] <= 1'b0; // R13
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chg1_reg <= CHG1_RST; // R18
    end else if (!sys_resetn) begin
      chg1_reg <= (chg1_reg & ~CHG1_SYS_MASK) | (CHG1_RST & CHG1_SYS_MASK); // R18
    end else if (wr_hit[3]) begin
      chg1_reg[7:4] <= w_data_reg[7:4];
      if (w_data_reg[ICHG_LSB +: 4] <= ICHG_MAX_CODE) begin
        chg1_reg[ICHG_LSB +: 4] <= w_data_reg[ICHG_LSB +: 4]; // R20
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chg2_reg <= CHG2_RST;
    end else if (wr_hit[4]) begin
      chg2_reg <= w_data_reg;
    end
  end

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------
  assign usb_path_select = path_reg[PATH_SEL_BIT]; // R2
  assign input_hold_voltage = path_reg[HOLD_LSB +: 3]; // R3
  assign supply_drive_pin = path_reg[DRIVE_BIT]; // R4
  assign shutdown_voltage = wake_reg[SHUTDOWN_VOLTAGE_LSB +: 3]; // R12
  assign rail_restart = wake_reg[RESTART_BIT]; // R7
  assign rails_disable = pwr_reg[PWR_OFF_BIT]; // R13
  assign battery_detect_en = pwr_reg[BATDET_BIT];
  assign power_down_reverse = pwr_reg[REVERSE_BIT]; // R16
  assign charger_enable = chg1_reg[CHG_EN_BIT];
  assign charger_target = chg1_reg[TARGET_LSB +: 2];
  assign charge_current_code = chg1_reg[ICHG_LSB +: 4];
  assign charger_keep_on = chg2_reg[KEEP_ON_BIT];
  assign charger_led_type_b = chg2_reg[LED_TYPE_BIT];
  assign target_tracks_current = chg2_reg[TRACK_BIT];
  assign irq_pin_masked = wake_reg[WAKE_EN_BIT] && !wake_reg[IRQ_NOWAKE_BIT]; // R10

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      default_ilim_ma <= ILIM_MA_01;
    end else begin
      unique case (path_reg[ILIM_LSB +: 2]) // R5
        2'h0: default_ilim_ma <= ILIM_MA_00;
        2'h1: default_ilim_ma <= ILIM_MA_01;
        2'h2: default_ilim_ma <= ILIM_MA_10;
        2'h3: default_ilim_ma <= ILIM_MA_11;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wakeup and power good
  // ----------------------------------------------------------------
  logic [31:0] pg_tick_cnt;
  logic pg_tick;
  logic [3:0] pg_ticks, pg_need, hold_ticks;
  logic hold_reg;
  pg_state_e pg_state;

  assign wake_fire = wake_reg[SOFTWAKE_BIT] ||
    (wake_reg[WAKE_EN_BIT] && !wake_reg[IRQ_NOWAKE_BIT] && irq_request); // R8 R10
  assign pg_tick = (pg_tick_cnt == 32'(PG_TICK_CYCLES - 1));
  assign pg_need = 4'h1 << pwr_reg[PG_DLY_LSB +: 2]; // R17

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rail_wakeup <= 1'b0;
    end else begin
      rail_wakeup <= wake_fire; // R8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || pg_tick) begin
      pg_tick_cnt <= 32'h0;
    end else begin
      pg_tick_cnt <= pg_tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pg_state <= PG_LOW;
      pg_ticks <= 4'h0;
    end else begin
      unique case (pg_state)
        PG_LOW: begin
          pg_ticks <= 4'h0;
          if (rails_good) pg_state <= PG_WAIT;
        end
        PG_WAIT: begin
          if (!rails_good) begin
            pg_state <= PG_LOW;
          end else if (pg_ticks >= pg_need) begin
            pg_state <= PG_GOOD; // R17
          end else if (pg_tick) begin
            pg_ticks <= pg_ticks + 4'h1;
          end
        end
        PG_GOOD: begin
          if (!rails_good) pg_state <= PG_LOW;
        end
        default: pg_state <= PG_LOW;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg <= 1'b0;
      hold_ticks <= 4'h0;
    end else if (wake_fire && wake_reg[WAKE_EN_BIT]) begin
      hold_reg <= wake_reg[PG_LOW_BIT]; // R11
      hold_ticks <= 4'h0;
    end else if (hold_ticks >= pg_need) begin
      hold_reg <= 1'b0;
    end else if (pg_tick) begin
      hold_ticks <= hold_ticks + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_good_output <= 1'b0;
    end else begin
      power_good_output <= (pg_state == PG_GOOD) && !hold_reg; // R11
    end
  end

  // ----------------------------------------------------------------
  // Charge LED pin
  // ----------------------------------------------------------------
  logic [31:0] led_tick_cnt;
  logic [3:0] led_phase;
  logic led_on;

  always_ff @(posedge aclk) begin
    if (!aresetn || led_tick_cnt == 32'(LED_TICK_CYCLES - 1)) begin
      led_tick_cnt <= 32'h0;
    end else begin
      led_tick_cnt <= led_tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_phase <= 4'h0;
    end else if (led_tick_cnt == 32'(LED_TICK_CYCLES - 1)) begin
      led_phase <= led_phase + 4'h1;
    end
  end

  always_comb begin
    unique case (pwr_reg[LED_LSB +: 2]) // R14
      LED_HIZ: led_on = 1'b0;
      LED_SLOW: led_on = led_phase < LED_SLOW_ON;
      LED_FAST: led_on = led_phase[1:0] == LED_FAST_PH;
      default: led_on = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge_led_pin_oe <= 1'b0;
    end else begin
      charge_led_pin_oe <= pwr_reg[LED_SRC_BIT] ? charger_led_request : led_on; // R15
    end
  end
  assign charge_led_pin_out = 1'b0;

  // ----------------------------------------------------------------
  // Charger end, safety timers and pass transistor
  // ----------------------------------------------------------------
  logic [15:0] set_ma, meas_scaled;
  logic [31:0] min_cnt;
  logic [9:0] minutes, limit_min;
  logic pre_q;
  logic [8:0] pass_cnt;
  logic pass_cut;

  assign set_ma = ICHG_STEP_MA * (16'(charge_current_code) + 16'h1); // R20
  assign meas_scaled = 16'(charge_current_ma) *
    16'(chg1_reg[END_BIT] ? END_MUL_20PCT : END_MUL_10PCT);
  assign limit_min = precharge_active ?
    PRE_BASE_MIN + PRE_STEP_MIN * 10'(chg2_reg[PRE_LSB +: 2]) :
    FAST_BASE_MIN + FAST_STEP_MIN * 10'(chg2_reg[FAST_LSB +: 2]); // R21

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge_done <= 1'b0;
    end else begin
      charge_done <= charger_enable && fastcharge_active && (meas_scaled < set_ma); // R19
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 1'b0;
      min_cnt <= 32'h0;
      minutes <= 10'h0;
    end else begin
      pre_q <= precharge_active;
      if (!(precharge_active || fastcharge_active) || pre_q != precharge_active) begin
        min_cnt <= 32'h0;
        minutes <= 10'h0;
      end else if (min_cnt == 32'(MINUTE_CYCLES - 1)) begin
        min_cnt <= 32'h0;
        if (minutes < limit_min) minutes <= minutes + 10'h1;
      end else begin
        min_cnt <= min_cnt + 32'h1;
      end
    end
  end
  assign charge_timeout = (minutes >= limit_min); // R21

  always_ff @(posedge aclk) begin
    if (!aresetn || !pass_on_request) begin
      pass_cnt <= 9'h0;
      pass_cut <= 1'b0;
    end else if (chg2_reg[PASS_LIM_BIT] && pass_cnt >= 9'(PASS_ON_CYC)) begin
      pass_cut <= 1'b1; // R22
    end else if (pass_cnt < 9'(PASS_ON_CYC)) begin
      pass_cnt <= pass_cnt + 9'h1;
    end
  end
  assign pass_gate = pass_on_request && !pass_cut; // R22

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence restart_written_s;
    wr_hit[1] && w_data_reg[RESTART_BIT];
  endsequence
  sequence restart_pulse_s;
    rail_restart ##1 !rail_restart;
  endsequence

  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
  unmapped_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready && reg_sel(araddr) == SEL_NONE |=> rvalid && rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  path_reserved_a: assert property (@(posedge aclk) disable iff (!aresetn)
    path_reg[PATH_RSV_BIT] == 1'b0) // R23
    else $error("reserved path bit set");
  sys_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !sys_resetn |=> !supply_drive_pin && !usb_path_select &&
    $stable(input_hold_voltage)) // R1
    else $error("system reset restored wrong path bits");
  restart_clear_a: assert property (@(posedge aclk) disable iff (!aresetn || !sys_resetn)
    restart_written_s |=> restart_pulse_s) // R7
    else $error("restart bit did not self-clear");
  disable_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rails_disable && !wr_hit[2] |=> !rails_disable) // R13
    else $error("power disable bit stuck");
  led_hiz_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !pwr_reg[LED_SRC_BIT] && pwr_reg[LED_LSB +: 2] == LED_HIZ |=> !charge_led_pin_oe) // R14
    else $error("led pin driven in high impedance mode");
  pg_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(power_good_output) |-> $past(rails_good, 2) && !$past(hold_reg)) // R17
    else $error("power good without rails");
  pass_cut_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pass_on_request && chg2_reg[PASS_LIM_BIT] && pass_cnt >= 9'(PASS_ON_CYC)
    ##1 pass_on_request |-> !pass_gate) // R22
    else $error("pass transistor not cut after on-time");
endmodule : power_path_charger_regs

// >>> tb/tb_power_path_charger_control_regs.sv
// Self-checking testbench for the power path and charger register bank
`timescale 1ns/1ns
module tb_power_path_charger_control_regs;
  import pmic_ctrl_pkg::*;
  logic aclk = 0, aresetn = 0, sys_resetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, irq_request = 0, rails_good = 1, charger_led_request = 0;
  logic precharge_active = 0, fastcharge_active = 0, pass_on_request = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic [3:0] wstrb = 4'hF, charge_current_code;
  logic [11:0] charge_current_ma = 0, default_ilim_ma;
  logic awready, wready, bvalid, arready, rvalid, usb_path_select, supply_drive_pin;
  logic [1:0] bresp, rresp, charger_target;
  logic [2:0] input_hold_voltage, shutdown_voltage;
  logic irq_pin_masked, rail_restart, rail_wakeup, rails_disable, power_down_reverse;
  logic power_good_output, battery_detect_en, charge_led_pin_out, charge_led_pin_oe;
  logic charger_led_type_b, charger_enable, charger_keep_on, target_tracks_current;
  logic charge_done, charge_timeout, pass_gate;
  int err_count = 0, n_tests = 0, cyc = 0, c;
  logic [7:0] n_wake = 0, n_rst = 0, n_dis = 0;
  logic [23:0] rows [6] = '{24'h30FFBF, 24'h33FEF5, 24'h331F15, 24'h34A6A6, 24'h310707,
    24'h320F0F};
  logic [11:0] ilim [4] = '{12'd900, 12'd1500, 12'd2000, 12'd2500};
  logic [7:0] rv [5] = '{8'h01, 8'h03, 8'h43, 8'hC5, 8'h45};
  int ledx [4] = '{0, 32, 32, 128};

  power_path_charger_regs #(.LED_TICK_CYCLES(8), .PG_TICK_CYCLES(4), .MINUTE_CYCLES(4))
    DUT (.*);

  initial forever #50 aclk = ~aclk;

  // Pulse counters and hang guard
  always @(posedge aclk) begin
    n_wake <= n_wake + (rail_wakeup === 1'b1);
    n_rst <= n_rst + (rail_restart === 1'b1);
    n_dis <= n_dis + (rails_disable === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic pa = 1, pw = 1;
    @(posedge aclk);
    awaddr <= {idx[5:0], 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (pa || pw) begin
      @(negedge aclk);
      if (awready) pa = 0;
      if (wready) pw = 0;
      @(posedge aclk);
      if (!pa) awvalid <= 0;
      if (!pw) wvalid <= 0;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    chk(bresp, er);
    @(posedge aclk);
    bready <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    araddr <= {idx[5:0], 2'b00};
    arvalid <= 1;
    rready <= 1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    chk(rdata, {24'h0, e});
    chk(rresp, er);
    @(posedge aclk);
    rready <= 0;
  endtask : rd

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    sys_resetn <= 1;
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    v[14:0] = {shutdown_voltage, power_down_reverse, battery_detect_en, charger_enable,
      charger_target, charge_current_code, charger_keep_on, charger_led_type_b,
      target_tracks_current};
    chk(v[14:0], 15'h782D);
    for (c = 0; c < 4; c++) begin
      v = c * 8'h55;
      wr(8'h30, v[7:0]);
      @(negedge aclk);
      chk({usb_path_select, input_hold_voltage, supply_drive_pin}, {v[7], v[5:3], v[2]});
      chk(default_ilim_ma, ilim[c]);
    end
    $display("table and path done");
    wr(8'h31, 8'h23);
    rd(8'h31, 8'h03);
    wr(8'h31, 8'h43);
    rd(8'h31, 8'h03);
    wr(8'h32, 8'hC3);
    rd(8'h32, 8'h43);
    chk({n_wake, n_rst, n_dis}, 24'h010101);
    for (c = 0; c < 2; c++) begin
      wr(8'h31, c ? 8'h1B : 8'h0B);
      chk(irq_pin_masked, !c);
      irq_request <= 1;
      repeat (4) @(posedge aclk);
      irq_request <= 0;
      rd(8'h31, c ? 8'h1B : 8'h03);
      chk(n_wake, 2);
    end
    wr(8'h32, 8'h40);
    rails_good <= 0;
    repeat (2) @(posedge aclk);
    rails_good <= 1;
    repeat (2) @(negedge aclk);
    chk(power_good_output, 0);
    repeat (12) @(negedge aclk);
    chk(power_good_output, 1);
    wr(8'h31, 8'hA8);
    repeat (2) @(negedge aclk);
    chk(power_good_output, 0);
    repeat (8) @(negedge aclk);
    chk(power_good_output, 1);
    for (c = 0; c < 4; c++) begin
      wr(8'h32, 8'(64 + 16 * c));
      v = 0;
      repeat (3) @(negedge aclk);
      repeat (128) begin
        @(negedge aclk);
        v += (charge_led_pin_oe === 1'b1);
      end
      chk(v, ledx[c]);
      chk(charge_led_pin_out, 0);
    end
    wr(8'h32, 8'h08);
    charger_led_request <= 1;
    @(negedge aclk);
    chk(charge_led_pin_oe, 0);
    @(negedge aclk);
    chk(charge_led_pin_oe, 1);
    $display("wake, power good and led done");
    wr(8'h34, 8'h4D);
    pass_on_request <= 1;
    repeat (300) @(negedge aclk);
    chk(pass_gate, 1);
    repeat (30) @(negedge aclk);
    chk(pass_gate, 0);
    @(posedge aclk);
    pass_on_request <= 0;
    @(posedge aclk);
    pass_on_request <= 1;
    @(negedge aclk);
    chk(pass_gate, 1);
    @(posedge aclk);
    fastcharge_active <= 1;
    charge_current_ma <= 130;
    for (c = 0; c < 3; c++) begin
      if (c == 2) charge_current_ma <= 100;
      wr(8'h33, c == 1 ? 8'hD5 : 8'hC5);
      repeat (3) @(negedge aclk);
      chk(charge_done, c != 0);
    end
    @(posedge aclk);
    fastcharge_active <= 0;
    precharge_active <= 1;
    repeat (190) @(negedge aclk);
    chk(charge_timeout, 0);
    repeat (20) @(negedge aclk);
    chk(charge_timeout, 1);
    $display("charger done");
    wr(8'h35, 8'hFF, RESP_SLVERR);
    rd(8'h35, 8'h00, RESP_SLVERR);
    wr(8'h30, 8'hFF);
    wr(8'h31, 8'h9B);
    wr(8'h33, 8'h45);
    @(posedge aclk);
    sys_resetn <= 0;
    @(posedge aclk);
    sys_resetn <= 1;
    rd(8'h30, 8'h3B);
    rd(8'h31, 8'h93);
    rd(8'h33, 8'hC5);
    @(posedge aclk);
    aresetn <= 0;
    @(posedge aclk);
    aresetn <= 1;
    foreach (rv[i]) rd(8'(48 + i), rv[i]);
    $display("reset done");
    give_verdict();
  end
endmodule : tb_power_path_charger_control_regs
